/* File: hw/uart_sleep_rs485_control.sv */
/*
  Sleep, low-power, auto request-to-send and 9-bit multi-drop control for
  one UART channel. All control bits except the receiver enable arrive as plain level ports.
  Assumes the baud generator, FIFOs and receiver shifter sit outside and
  report their state synchronously to core_clk_in.

  // Overview of operation
  // RQ1: sleep armed only with enhanced functions and both channels' sleep enable set
  // RQ2: without the ignore option, receive line must idle four character times
  // RQ3: with the ignore option, the receive line is not looked at
  // RQ4: sleep also needs quiet modem inputs, empty FIFOs and shifter, no interrupt
  // RQ5: while asleep, the UART and baud clocks are stopped
  // RQ6: host must not write the baud divisor while asleep
  // RQ7: start bit, transmit FIFO write or modem change wakes the device
  // RQ8: after waking, sleep resumes by itself until sleep enable is cleared
  // RQ9: low-power input stops all clocks and isolates bus until released
  // RQ10: auto RS-485 mode overrides manual and flow-control request-to-send
  // RQ11: auto mode drives request-to-send low on write, high after last bit
  // RQ12: software disables hardware flow control before auto RS-485 mode
  // RQ13: inversion makes request-to-send high while pending, low when done
  // RQ14: 9-bit mode treats a character with ninth bit one as address
  // RQ15: software disables all flow control before automatic 9-bit mode
  // RQ16: software forces parity zero for normal multi-drop address detection
  // RQ17: receiver off drops data; address sets parity error, stored, interrupts
  // RQ18: receiver on keeps receiving; later addresses flag parity error again
  // RQ19: controller enables receiver only for its own address
  // RQ20: auto detection compares addresses with the second flow-off character
  // RQ21: matching address enables receiver, stored with parity-error bit, interrupts
  // RQ22: non-matching later address disables receiver and is discarded
*/
`timescale 1ns/10ps
`include "uart_sleep_regs.svh"

module uart_sleep_rs485_control (
  input wire logic core_clk_in, // 20 MHz core clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic enh_func_en_in, // enhanced_feature_reg enhanced functions bit
  input wire logic sleep_en_a_in, // interrupt_enable_reg sleep bit, channel a
  input wire logic sleep_en_b_in, // interrupt_enable_reg sleep bit, channel b
  input wire logic sleep_ignore_rx_in, // advanced_control_reg_one bit 4
  input wire logic low_power_input_in, // low-power pin, active high
  input wire logic baud_tick_in, // 16x baud enable pulse
  input wire logic serial_in_in, // serial receive line
  input wire logic [3:0] modem_in, // modem input pins
  input wire logic tx_fifo_write_in, // host write into transmit FIFO, pulse
  input wire logic tx_fifo_empty_in, // transmit FIFO empty
  input wire logic tx_shift_empty_in, // transmit shift register empty
  input wire logic rx_fifo_empty_in, // receive FIFO empty
  input wire logic irq_pending_in, // any interrupt pending
  input wire logic auto_rts_en_in, // advanced_control_reg_two bit 4
  input wire logic rts_invert_in, // advanced_control_reg_two bit 5
  input wire logic manual_rts_in, // modem_control_reg request-to-send level
  input wire logic hw_flow_en_in, // hardware flow control enabled
  input wire logic hw_flow_rts_in, // flow control request-to-send level
  input wire logic nine_bit_en_in, // advanced_control_reg_two bit 0
  input wire logic special_char_en_in, // enhanced_feature_reg special char detect
  input wire logic [`CHAR_W-1:0] second_flow_off_char_in, // station address
  input wire logic line_status_ie_in, // interrupt_enable_reg line status bit
  input wire logic rx_enable_set_in, // software receiver enable, pulse
  input wire logic rx_enable_clr_in, // software receiver disable, pulse
  input wire logic rx_char_valid_in, // received character strobe
  input wire logic [`CHAR_W-1:0] rx_char_data_in, // received character
  input wire logic rx_char_ninth_in, // received ninth (parity) bit
  input wire logic rx_char_perr_in, // parity error for plain reception
  output logic clk_run_out, // UART and baud clock enable
  output logic bus_isolate_out, // host interface isolation
  output uart_power_pkg::pwr_state_t power_state_out, // power state
  output logic request_to_send_pin_out, // request-to-send pin level
  output logic rx_enabled_out, // receiver enable state
  output logic rx_push_out, // push into receive FIFO, pulse
  output logic [`CHAR_W-1:0] rx_push_data_out, // pushed character
  output logic rx_push_perr_out, // parity-error status with the push
  output logic line_status_irq_out // line status interrupt request, pulse
);
  import uart_power_pkg::*;

  localparam logic [`IDLE_CNT_W-1:0] IDLE_TICKS =
    `IDLE_CNT_W'(`IDLE_CHAR_COUNT * `BITS_PER_CHAR * `BAUD_TICKS_PER_BIT);

  //////////////////////////////////////////////////////////////////////////////
  // sleep entry and wake conditions

  pwr_state_t state_q;
  pwr_state_t state_d;
  logic [3:0] modem_prev_q;
  logic rx_idle;
  logic sleep_armed;
  logic modem_change;
  logic enter_ok;
  logic wake;

  // the idle count only advances while the baud clock runs
  idle_line_timer #(
    .LIMIT(IDLE_TICKS)
  ) u_idle (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(baud_tick_in && clk_run_out),
    .line_in(serial_in_in),
    .idle_out(rx_idle)
  );

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      modem_prev_q <= 4'h0;
    end else begin
      modem_prev_q <= modem_in;
    end
  end

  assign sleep_armed = enh_func_en_in && sleep_en_a_in && sleep_en_b_in; // RQ1
  assign modem_change = (modem_in != modem_prev_q);

  always_comb begin
    enter_ok = sleep_armed && !modem_change; // RQ4
    enter_ok = enter_ok && (sleep_ignore_rx_in || rx_idle); // RQ2 RQ3
    enter_ok = enter_ok && tx_fifo_empty_in && tx_shift_empty_in && !tx_fifo_write_in; // RQ4
    enter_ok = enter_ok && rx_fifo_empty_in && !irq_pending_in; // RQ4
  end

  // start bit, transmit write, modem edge, or loss of arming
  assign wake = !serial_in_in || tx_fifo_write_in || modem_change || !sleep_armed; // RQ7

  //////////////////////////////////////////////////////////////////////////////
  // power state machine

  always_comb begin
    state_d = state_q;
    if (low_power_input_in) begin
      state_d = PWR_LOW_POWER_INPUT; // RQ9
    end else begin
      case (state_q)
        PWR_AWAKE: begin
          if (enter_ok) begin
            state_d = PWR_ASLEEP; // RQ8
          end
        end
        PWR_ASLEEP: begin
          if (wake) begin
            state_d = PWR_AWAKE; // RQ7
          end
        end
        PWR_LOW_POWER_INPUT: begin
          state_d = PWR_AWAKE; // RQ9
        end
        default: begin
          state_d = PWR_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_q <= PWR_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs follow the next state so they line up with state_q
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      clk_run_out <= 1'b1;
      bus_isolate_out <= 1'b0;
      power_state_out <= PWR_AWAKE;
    end else begin
      clk_run_out <= (state_d == PWR_AWAKE); // RQ5 RQ9
      bus_isolate_out <= (state_d == PWR_LOW_POWER_INPUT); // RQ9
      power_state_out <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // auto RS-485 request-to-send

  logic tx_busy_q;
  logic tx_busy_d;

  // a write in the same cycle as the drain wins, so no frame loses its driver
  always_comb begin
    tx_busy_d = tx_busy_q;
    if (tx_fifo_write_in) begin
      tx_busy_d = 1'b1; // RQ11
    end else if (tx_fifo_empty_in && tx_shift_empty_in) begin
      tx_busy_d = 1'b0; // RQ11
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tx_busy_q <= 1'b0;
    end else begin
      tx_busy_q <= tx_busy_d;
    end
  end

  // flow control is expected off in auto mode; auto still wins if not
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      request_to_send_pin_out <= `RTS_DEASSERTED;
    end else if (auto_rts_en_in) begin
      request_to_send_pin_out <= tx_busy_d ? (`RTS_ASSERTED ^ rts_invert_in) // RQ10 RQ11 RQ13
                                           : (`RTS_DEASSERTED ^ rts_invert_in); // RQ13
    end else if (hw_flow_en_in) begin
      request_to_send_pin_out <= hw_flow_rts_in;
    end else begin
      request_to_send_pin_out <= manual_rts_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 9-bit multi-drop receive filter

  logic rx_en_q;
  logic rx_en_d;
  logic is_addr;
  logic addr_match;
  logic auto_addr;
  logic push_d;
  logic perr_d;
  logic irq_d;
  logic hw_set;
  logic hw_clr;

  assign is_addr = nine_bit_en_in && rx_char_ninth_in; // RQ14
  assign addr_match = (rx_char_data_in == second_flow_off_char_in); // RQ20
  assign auto_addr = nine_bit_en_in && special_char_en_in;

  always_comb begin
    push_d = 1'b0;
    perr_d = 1'b0;
    irq_d = 1'b0;
    hw_set = 1'b0;
    hw_clr = 1'b0;
    if (rx_char_valid_in) begin
      if (!nine_bit_en_in) begin
        push_d = rx_en_q;
        perr_d = rx_char_perr_in;
        irq_d = rx_en_q && rx_char_perr_in && line_status_ie_in;
      end else if (!is_addr) begin
        push_d = rx_en_q; // RQ17 RQ18 RQ20
      end else if (!auto_addr) begin
        push_d = 1'b1; // RQ17 RQ18
        perr_d = 1'b1;
        irq_d = line_status_ie_in;
      end else if (addr_match) begin
        push_d = 1'b1; // RQ21
        perr_d = rx_char_ninth_in;
        irq_d = line_status_ie_in;
        hw_set = 1'b1;
      end else begin
        hw_clr = 1'b1; // RQ22
      end
    end
  end

  // an enable arriving with a disable wins, so a matched address is kept
  always_comb begin
    rx_en_d = rx_en_q;
    if (rx_enable_set_in || hw_set) begin
      rx_en_d = 1'b1; // RQ21
    end else if (rx_enable_clr_in || hw_clr) begin
      rx_en_d = 1'b0; // RQ22
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rx_en_q <= `RX_EN_RESET;
      rx_enabled_out <= `RX_EN_RESET;
    end else begin
      rx_en_q <= rx_en_d;
      rx_enabled_out <= rx_en_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rx_push_out <= 1'b0;
      rx_push_data_out <= 8'h00;
      rx_push_perr_out <= 1'b0;
      line_status_irq_out <= 1'b0;
    end else begin
      rx_push_out <= push_d;
      rx_push_data_out <= rx_char_data_in;
      rx_push_perr_out <= perr_d;
      line_status_irq_out <= irq_d; // RQ17 RQ21
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_woken;
    state_q == PWR_ASLEEP ##1 state_q == PWR_AWAKE;
  endsequence

  sequence s_ready_again;
    enter_ok && !low_power_input_in;
  endsequence

  property p_arm;
    (state_q == PWR_AWAKE && !sleep_armed) |=> state_q != PWR_ASLEEP;
  endproperty
  a_arm: assert property (p_arm) else $error("slept while unarmed"); // RQ1

  property p_rx_busy;
    (state_q == PWR_AWAKE && !sleep_ignore_rx_in && !rx_idle) |=> state_q != PWR_ASLEEP;
  endproperty
  a_rx_busy: assert property (p_rx_busy) else $error("slept with busy receive line"); // RQ2

  property p_ignore_rx;
    (state_q == PWR_AWAKE && sleep_ignore_rx_in && !serial_in_in && enter_ok
      && !low_power_input_in) |=> state_q == PWR_ASLEEP;
  endproperty
  a_ignore_rx: assert property (p_ignore_rx) else $error("line state blocked sleep"); // RQ3

  property p_busy_stay;
    (state_q == PWR_AWAKE && (!tx_fifo_empty_in || !rx_fifo_empty_in || irq_pending_in))
      |=> state_q != PWR_ASLEEP;
  endproperty
  a_busy_stay: assert property (p_busy_stay) else $error("slept with work pending"); // RQ4

  property p_clk_stop;
    state_q != PWR_AWAKE |-> !clk_run_out;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock runs while asleep"); // RQ5

  property p_wake;
    (state_q == PWR_ASLEEP && !low_power_input_in && (tx_fifo_write_in || !serial_in_in))
      |=> state_q == PWR_AWAKE && clk_run_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on event"); // RQ7

  property p_resleep;
    s_woken ##0 s_ready_again |=> state_q == PWR_ASLEEP;
  endproperty
  a_resleep: assert property (p_resleep) else $error("no return to sleep"); // RQ8

  property p_low_power_input;
    low_power_input_in |=> state_q == PWR_LOW_POWER_INPUT && bus_isolate_out && !clk_run_out;
  endproperty
  a_low_power_input: assert property (p_low_power_input) else $error("low power not entered"); // RQ9

  property p_low_power_input_exit;
    (state_q == PWR_LOW_POWER_INPUT && !low_power_input_in) |=> state_q == PWR_AWAKE ##0 clk_run_out;
  endproperty
  a_low_power_input_exit: assert property (p_low_power_input_exit) else $error("low power not left"); // RQ9

  property p_rts_override;
    (auto_rts_en_in && !rts_invert_in && tx_busy_q && !(tx_fifo_empty_in && tx_shift_empty_in))
      |=> request_to_send_pin_out == `RTS_ASSERTED;
  endproperty
  a_rts_override: assert property (p_rts_override) else $error("rts not overridden"); // RQ10

  property p_rts_write;
    (auto_rts_en_in && !rts_invert_in && tx_fifo_write_in) |=> !request_to_send_pin_out;
  endproperty
  a_rts_write: assert property (p_rts_write) else $error("rts not driven low"); // RQ11

  property p_rts_inv;
    (auto_rts_en_in && rts_invert_in && tx_fifo_write_in) |=> request_to_send_pin_out;
  endproperty
  a_rts_inv: assert property (p_rts_inv) else $error("inverted rts not high"); // RQ13

  property p_drop_data;
    (rx_char_valid_in && nine_bit_en_in && !rx_char_ninth_in && !rx_en_q) |=> !rx_push_out;
  endproperty
  a_drop_data: assert property (p_drop_data) else $error("data kept while off"); // RQ17

  property p_addr_normal;
    (rx_char_valid_in && is_addr && !special_char_en_in)
      |=> rx_push_out && rx_push_perr_out && line_status_irq_out == $past(line_status_ie_in);
  endproperty
  a_addr_normal: assert property (p_addr_normal) else $error("address not flagged"); // RQ14

  property p_keep_rx;
    (rx_char_valid_in && nine_bit_en_in && !rx_char_ninth_in && rx_en_q)
      |=> rx_push_out && !rx_push_perr_out;
  endproperty
  a_keep_rx: assert property (p_keep_rx) else $error("data lost while on"); // RQ18

  property p_match;
    (rx_char_valid_in && is_addr && auto_addr && addr_match)
      |=> rx_push_out && rx_push_perr_out && rx_enabled_out;
  endproperty
  a_match: assert property (p_match) else $error("match not taken"); // RQ21

  property p_nomatch;
    (rx_char_valid_in && is_addr && auto_addr && !addr_match && !rx_enable_set_in)
      |=> !rx_push_out && !rx_enabled_out;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("mismatch not dropped"); // RQ22

endmodule

/* File: hw/uart_sleep_regs.svh */
/*
  Named constants for the sleep and RS-485 control block: idle timing,
  request-to-send levels and receiver defaults.
  Assumes a 16x baud enable and a ten-bit character frame.
*/
`ifndef UART_SLEEP_REGS_SVH
`define UART_SLEEP_REGS_SVH

`define IDLE_CHAR_COUNT 4
`define BITS_PER_CHAR 10
`define BAUD_TICKS_PER_BIT 16
`define IDLE_CNT_W 10
`define IDLE_CNT_ZERO 10'h000
`define IDLE_CNT_ONE 10'h001
`define RTS_ASSERTED 1'b0
`define RTS_DEASSERTED 1'b1
`define RX_EN_RESET 1'b1
`define CHAR_W 8

`endif

/* File: hw/uart_power_pkg.sv */
/*
  Types shared by the sleep and RS-485 control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uart_power_pkg;

  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_ASLEEP,
    PWR_LOW_POWER_INPUT
  } pwr_state_t;

endpackage

/* File: hw/idle_line_timer.sv */
/*
  Receive line idle timer: counts baud enables while the line is high and
  flags idle once the limit is reached.
  Assumes tick_in is a one-cycle enable synchronous to clk_in.
*/
`timescale 1ns/10ps
`include "uart_sleep_regs.svh"

module idle_line_timer #(
  parameter logic [`IDLE_CNT_W-1:0] LIMIT = 10'h280
) (
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic tick_in, // baud enable
  input wire logic line_in, // serial receive level
  output logic idle_out // line held high for LIMIT ticks
);

  logic [`IDLE_CNT_W-1:0] cnt_q;

  // saturates so a long idle period never wraps back to busy
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= `IDLE_CNT_ZERO;
    end else if (!line_in) begin
      cnt_q <= `IDLE_CNT_ZERO;
    end else if (tick_in && cnt_q != LIMIT) begin
      cnt_q <= cnt_q + `IDLE_CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      idle_out <= 1'b0;
    end else begin
      idle_out <= line_in && (cnt_q == LIMIT);
    end
  end

  property p_idle_drop;
    @(posedge clk_in) disable iff (!rst_n_in)
    !line_in |=> !idle_out;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("idle kept after line low"); // RQ2

endmodule

/* File: bench/uart_line_partner.sv */
/*
  Far-side model: baud enable source and the transmit path that the host
  fills, reporting FIFO and shifter empty as a real transmitter would.
  Assumes host writes are one-cycle pulses sampled on the rising edge.
*/
`timescale 1ns/10ps

module uart_line_partner #(
  parameter int TICK_DIV = 2,
  parameter int SHIFT_CYC = 6
) (
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic tx_write_in, // host write into transmit FIFO
  input wire logic slow_in, // stretch each character threefold
  output logic baud_tick_out, // 16x baud enable
  output logic tx_fifo_empty_out, // transmit FIFO empty
  output logic tx_shift_empty_out // shift register empty
);
  int tick_cnt;
  int fifo_cnt;
  int shift_cnt;
  logic load;

  assign load = (shift_cnt == 0) && (fifo_cnt > 0);
  assign tx_fifo_empty_out = (fifo_cnt == 0);
  assign tx_shift_empty_out = (shift_cnt == 0);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_cnt <= 0;
      baud_tick_out <= 1'b0;
    end else begin
      tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
      baud_tick_out <= (tick_cnt == TICK_DIV - 1);
    end
  end

  // shifter stays busy for the whole frame so the last bit is really out
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fifo_cnt <= 0;
      shift_cnt <= 0;
    end else begin
      fifo_cnt <= fifo_cnt + int'(tx_write_in) - int'(load);
      if (load) begin
        shift_cnt <= slow_in ? 3 * SHIFT_CYC : SHIFT_CYC;
      end else if (shift_cnt > 0) begin
        shift_cnt <= shift_cnt - 1;
      end
    end
  end
endmodule

/* File: bench/uart_sleep_rs485_control_tb_top.sv */
/*
  Self-checking bench: power-state sequences, request-to-send and the
  multi-drop receive filter against a cycle model.
  Assumes the far-side partner model and a 20 MHz core clock.
*/
`timescale 1ns/10ps
`include "uart_sleep_regs.svh"

module uart_sleep_rs485_control_tb_top;
  import uart_power_pkg::*;
  logic clk, rst_n, sl_a, sl_b, ign, lowp, ser, wr, auto, inv, man, flow, hrts;
  logic nine, spec, ie, rset, rclr, rv, r9, rpe, slow, cmp_rts, cmp_rx;
  logic [3:0] modem;
  logic [`CHAR_W-1:0] station, rd, pdata, m_data;
  logic clk_run, iso, rts, rx_en, push, pperr, lirq, tick, fe_p, se_p, fe_w, se_w;
  logic m_pend, m_rts, m_en, m_push, m_perr, m_irq, m_set, m_clr;
  pwr_state_t pst;
  int blk, err_count, n_compared, cyc, early;

  assign fe_w = fe_p & (blk != 2);
  assign se_w = se_p & (blk != 3);

  uart_line_partner uart_line_partner_inst (.clk_in(clk), .rst_n_in(rst_n),
    .tx_write_in(wr), .slow_in(slow), .baud_tick_out(tick),
    .tx_fifo_empty_out(fe_p), .tx_shift_empty_out(se_p));

  uart_sleep_rs485_control uart_sleep_rs485_control_inst (.core_clk_in(clk),
    .rst_n_in(rst_n), .enh_func_en_in(blk != 0), .sleep_en_a_in(sl_a),
    .sleep_en_b_in(sl_b & (blk != 1)), .sleep_ignore_rx_in(ign),
    .low_power_input_in(lowp), .baud_tick_in(tick), .serial_in_in(ser), .modem_in(modem),
    .tx_fifo_write_in(wr), .tx_fifo_empty_in(fe_w), .tx_shift_empty_in(se_w),
    .rx_fifo_empty_in(blk != 4), .irq_pending_in(blk == 5), .auto_rts_en_in(auto),
    .rts_invert_in(inv), .manual_rts_in(man), .hw_flow_en_in(flow), .hw_flow_rts_in(hrts),
    .nine_bit_en_in(nine), .special_char_en_in(spec), .second_flow_off_char_in(station),
    .line_status_ie_in(ie), .rx_enable_set_in(rset), .rx_enable_clr_in(rclr),
    .rx_char_valid_in(rv), .rx_char_data_in(rd), .rx_char_ninth_in(r9),
    .rx_char_perr_in(rpe), .clk_run_out(clk_run), .bus_isolate_out(iso),
    .power_state_out(pst), .request_to_send_pin_out(rts), .rx_enabled_out(rx_en),
    .rx_push_out(push), .rx_push_data_out(pdata), .rx_push_perr_out(pperr),
    .line_status_irq_out(lirq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_pst(input pwr_state_t s, input int lim);
    for (int i = 0; i < lim && pst !== s; i++) @(negedge clk);
    check("power state", 8'(pst), 8'(s));
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle model of request-to-send and the receive filter
  always @(posedge clk) begin
    if (!rst_n) begin
      m_pend = 1'b0;
      m_rts = `RTS_DEASSERTED;
      m_en = `RX_EN_RESET;
      m_push = 1'b0;
      m_irq = 1'b0;
    end else begin
      m_pend = wr ? 1'b1 : (fe_w & se_w) ? 1'b0 : m_pend;
      m_rts = auto ? ((m_pend ? `RTS_ASSERTED : `RTS_DEASSERTED) ^ inv) : (flow ? hrts : man);
      m_set = rset;
      m_clr = rclr;
      m_push = 1'b0;
      m_irq = 1'b0;
      if (rv) begin
        if (!nine) begin
          m_push = m_en;
          m_perr = rpe;
          m_irq = m_en & rpe & ie;
        end else if (!r9) begin
          m_push = m_en;
          m_perr = 1'b0;
        end else if (!spec || rd == station) begin
          m_push = 1'b1;
          m_perr = 1'b1;
          m_irq = ie;
          m_set = m_set | spec;
        end else begin
          m_clr = 1'b1;
        end
        if (m_push) m_data = rd;
      end
      m_en = m_set ? 1'b1 : m_clr ? 1'b0 : m_en;
    end
  end

  always @(negedge clk) begin
    if (cmp_rts) check("rts pin", 8'(rts), 8'(m_rts));
    if (cmp_rx) begin
      check("push", 8'(push), 8'(m_push));
      check("rx enable", 8'(rx_en), 8'(m_en));
      check("line irq", 8'(lirq), 8'(m_irq));
      if (m_push) begin
        check("push data", pdata, m_data);
        check("push perr", 8'(pperr), 8'(m_perr));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, sl_a, sl_b, ign, lowp, wr, auto, inv, man, flow, hrts} = 11'h000;
    {nine, spec, ie, rset, rclr, rv, r9, rpe, slow, cmp_rts, cmp_rx} = 11'h000;
    {ser, modem, station, rd} = 21'h10_0000;
    {blk, err_count, n_compared, cyc, early} = '0;
    void'($urandom(79542));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check("reset state", 8'({clk_run, iso, rts, rx_en, push, lirq}), 8'h2c);
    check("reset power", 8'(pst), 8'(PWR_AWAKE));
    $display("test reset done");

    // entry refused while one of enhanced, sleep enable b, FIFO, shifter, interrupt or modem conditions fails
    {ign, sl_a, sl_b} = 3'h7;
    for (int b = 0; b < 7; b++) begin
      @(negedge clk);
      sl_a = 1'b0;
      @(negedge clk);
      blk = b;
      sl_a = 1'b1;
      // toggling starts with the unblock, else one quiet cycle lets it sleep
      repeat (20) begin
        if (b == 6) modem = modem + 4'h1;
        @(negedge clk);
      end
      check("blocked entry", 8'(pst), 8'(PWR_AWAKE));
    end
    blk = 7;
    wait_pst(PWR_ASLEEP, 10);
    check("clock stopped", 8'(clk_run), 8'h00);
    $display("test sleep entry done");

    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      if (k == 0) wr = 1'b1;
      if (k == 1) modem = modem ^ 4'(1 << ($urandom % 4));
      if (k == 2) ser = 1'b0;
      @(negedge clk);
      {wr, ser} = 2'h1;
      check("woken", 8'(pst), 8'(PWR_AWAKE));
      check("clock runs", 8'(clk_run), 8'h01);
      wait_pst(PWR_ASLEEP, 100);
    end
    $display("test wake done");

    @(negedge clk);
    lowp = 1'b1;
    @(negedge clk);
    wr = 1'b1;
    check("low power", 8'({pst, iso, clk_run}), 8'({PWR_LOW_POWER_INPUT, 2'h2}));
    @(negedge clk);
    wr = 1'b0;
    repeat (5) @(negedge clk);
    check("low power held", 8'({pst, iso, clk_run}), 8'({PWR_LOW_POWER_INPUT, 2'h2}));
    {lowp, sl_b} = 2'h0;
    @(negedge clk);
    check("low power left", 8'({pst, iso, clk_run}), 8'({PWR_AWAKE, 2'h1}));
    repeat (30) @(negedge clk);
    check("disabled stays awake", 8'(pst), 8'(PWR_AWAKE));
    $display("test low power done");

    // line must idle 640 baud ticks, two core cycles per tick
    {ign, ser} = 2'h0;
    @(negedge clk);
    {ser, sl_b} = 2'h3;
    repeat (1200) begin
      @(negedge clk);
      if (pst !== PWR_AWAKE) early++;
    end
    check("early sleep", 8'(early), 8'h00);
    wait_pst(PWR_ASLEEP, 200);
    // sleep enable dropped first, so a later divisor change is safe
    sl_a = 1'b0;
    $display("test idle line done");

    cmp_rts = 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 400 && !(fe_p && se_p); i++) @(negedge clk);
      flow = (p == 1);
      {auto, inv, slow} = {p > 1, p == 3, p == 3};
      repeat (120) begin
        @(negedge clk);
        wr = ($urandom % 16 == 0);
        {man, hrts} = 2'($urandom);
      end
      @(negedge clk);
      wr = 1'b0;
    end
    repeat (80) @(negedge clk);
    cmp_rts = 1'b0;
    $display("test request to send done");

    flow = 1'b0;
    cmp_rx = 1'b1;
    for (int m = 0; m < 3; m++) begin
      {nine, spec, ie} = {m > 0, m == 2, 1'($urandom)};
      station = 8'($urandom);
      repeat (80) begin
        @(negedge clk);
        {rv, rset, rclr} = 3'h0;
        case ($urandom % 8)
          0, 1, 2, 3, 4: begin
            rv = 1'b1;
            rd = ($urandom % 4 == 0) ? station : 8'($urandom);
            r9 = ($urandom % 3 == 0);
            rpe = 1'($urandom);
          end
          5: rset = (rd == station);
          6: rclr = 1'b1;
          default: ;
        endcase
      end
      @(negedge clk);
      {rv, rset, rclr} = 3'h0;
    end
    repeat (3) @(negedge clk);
    cmp_rx = 1'b0;
    $display("test multi-drop done");
    final_report();
  end
endmodule
